// [hdl/rps_pin_supervision.sv]
// reset pin supervision, oscillator halt flag and shared irq/wave pin of a serial rtc
// How it works
// R1 - recovery delay before reset release applies only with oscillator enabled and running
// R2 - oscillator disable bit set skips recovery delay, reset released at once
// R3 - reset output level never gates register, timekeeping or oscillator logic
// R4 - halt flag sets after oscillator stays stopped for detection time
// R5 - irq mode bit 0 puts square wave on shared pin, rate bits pick it
// R6 - irq mode bit 1 drives shared pin low on enabled alarm match
// R7 - at power-up irq mode is 1 and both alarms disabled
// R8 - irq mode bit lives in control register at address 0eh
// R9 - enabled 32khz output toggles on primary or backup supply
// R10 - reset held low while supply fails, released after hold time above threshold
// R11 - external pushbutton low on reset pin requests a full reset pulse
// R12 - button low accepted only after stable for debounce time
// R13 - accepted button request holds reset low for reset active time
`default_nettype none
module rps_pin_supervision
  import rps_pkg::*;
#(
  parameter logic [CNT_W-1:0] T_RST = CNT_W'(T_RST_CYC),
  parameter logic [CNT_W-1:0] T_REC = CNT_W'(T_REC_CYC),
  parameter logic [CNT_W-1:0] T_BUTTON_SETTLE_TIME = CNT_W'(BUTTON_SETTLE_TIME_CYC),
  parameter logic [CNT_W-1:0] T_OSF = CNT_W'(OSF_CYC)
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic vcc_ok,
  input wire logic osc_running,
  input wire logic en_32khz,
  input wire logic alarm1_match,
  input wire logic alarm2_match,
  input wire logic osc_halt_clr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [7:0] control_config,
  output logic osc_halt_flag,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic irq_or_wave_pin_out,
  output logic irq_or_wave_pin_oe,
  output logic clk32_pin_out,
  output logic clk32_pin_oe
);
  rps_lvl_if vcc_if ();
  rps_lvl_if osc_if ();
  rps_lvl_if pin_if ();
  rps_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] osf_cnt;
  logic [CNT_W-1:0] wave_cnt;
  logic [CNT_W-1:0] wave_half;
  logic [CNT_W-1:0] k32_cnt;
  logic [CNT_W-1:0] rec_limit;
  logic wave;
  logic osc_dis;
  logic alarm_hit;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  assign vcc_if.raw = vcc_ok;
  assign osc_if.raw = osc_running;
  assign pin_if.raw = rst_pin_in;

  rps_filt u_vcc (.ref_clk(ref_clk), .rstn(rstn), .init_val(1'b0), .lvl(vcc_if.filt));
  rps_filt u_osc (.ref_clk(ref_clk), .rstn(rstn), .init_val(1'b0), .lvl(osc_if.filt));
  rps_filt u_pin (.ref_clk(ref_clk), .rstn(rstn), .init_val(1'b1), .lvl(pin_if.filt));

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // the reset pin state is never consulted here, so access continues while it is low
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      control_config <= CTRL_RESET; // R7
    else if (reg_wr && reg_addr == CTRL_ADDR) // R8 R3
      control_config <= reg_wdata;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      reg_rdata <= RDATA_NONE;
    else if (reg_addr == CTRL_ADDR)
      reg_rdata <= control_config;
    else
      reg_rdata <= RDATA_NONE;
  end

  assign osc_dis = control_config[CTL_OSC_DIS];

  // ----------------------------------------
  // reset pin sequencer
  // ----------------------------------------
  // recovery delay only when the oscillator is enabled and running
  assign rec_limit = osc_if.clean ? T_REC : T_RST; // R1

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state <= ST_PFAIL;
      cnt <= '0;
      rst_pin_oe <= 1'b0;
    end
    else
    begin
      case (state)
        ST_PFAIL:
        begin
          cnt <= '0;
          rst_pin_oe <= 1'b0; // R10
          if (vcc_if.clean && osc_dis)
          begin
            state <= ST_RUN; // R2
            rst_pin_oe <= 1'b1;
          end
          else if (vcc_if.clean)
            state <= ST_RECOVER;
        end
        ST_RECOVER:
        begin
          if (!vcc_if.clean)
          begin
            state <= ST_PFAIL;
            cnt <= '0;
          end
          else if (osc_dis)
          begin
            state <= ST_RUN; // R2
            cnt <= '0;
            rst_pin_oe <= 1'b1;
          end
          else if (cnt >= rec_limit - CNT_W'(1)) // R1 R10
          begin
            state <= ST_RUN;
            cnt <= '0;
            rst_pin_oe <= 1'b1;
          end
          else
            cnt <= cnt + CNT_W'(1);
        end
        ST_RUN:
        begin
          if (!vcc_if.clean)
          begin
            state <= ST_PFAIL; // R10
            cnt <= '0;
            rst_pin_oe <= 1'b0;
          end
          else if (!pin_if.clean) // R11
          begin
            if (cnt >= T_BUTTON_SETTLE_TIME - CNT_W'(1)) // R12
            begin
              state <= ST_PULSE;
              cnt <= '0;
              rst_pin_oe <= 1'b0;
            end
            else
              cnt <= cnt + CNT_W'(1);
          end
          else
            cnt <= '0; // R12
        end
        ST_PULSE:
        begin
          if (!vcc_if.clean)
          begin
            state <= ST_PFAIL;
            cnt <= '0;
          end
          else if (cnt >= T_RST - CNT_W'(1)) // R13
          begin
            state <= ST_RUN;
            cnt <= '0;
            rst_pin_oe <= 1'b1;
          end
          else
            cnt <= cnt + CNT_W'(1);
        end
        default:
        begin
          state <= ST_PFAIL;
          cnt <= '0;
          rst_pin_oe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // oscillator halt flag
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      osf_cnt <= '0;
    else if (osc_if.clean)
      osf_cnt <= '0;
    else if (osf_cnt < T_OSF)
      osf_cnt <= osf_cnt + CNT_W'(1);
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      osc_halt_flag <= OSF_RESET;
    else if (!osc_if.clean && osf_cnt == T_OSF - CNT_W'(1)) // R4
      osc_halt_flag <= 1'b1;
    else if (osc_halt_clr)
      osc_halt_flag <= 1'b0;
  end

  // ----------------------------------------
  // square wave and shared pin
  // ----------------------------------------
  always_comb
  begin
    case ({control_config[CTL_RS_HI], control_config[CTL_RS_LO]}) // R5
      2'b00: wave_half = CNT_W'(WAVE_1HZ_HALF);
      2'b01: wave_half = CNT_W'(WAVE_1K_HALF);
      2'b10: wave_half = CNT_W'(WAVE_4K_HALF);
      default: wave_half = CNT_W'(WAVE_8K_HALF);
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      wave_cnt <= '0;
      wave <= 1'b1;
    end
    else if (wave_cnt >= wave_half - CNT_W'(1))
    begin
      wave_cnt <= '0;
      wave <= ~wave;
    end
    else
      wave_cnt <= wave_cnt + CNT_W'(1);
  end

  assign alarm_hit = (alarm1_match && control_config[CTL_A1_EN]) ||
                     (alarm2_match && control_config[CTL_A2_EN]);

  // open drain: enable low pulls the pin low
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      irq_or_wave_pin_out <= 1'b0;
      irq_or_wave_pin_oe <= 1'b1;
    end
    else if (control_config[CTL_IRQ_MODE])
      irq_or_wave_pin_oe <= ~alarm_hit; // R6
    else
      irq_or_wave_pin_oe <= wave; // R5
  end

  // ----------------------------------------
  // 32khz output and constant pin levels
  // ----------------------------------------
  // no supply input is consulted, so it runs the same on either supply
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      k32_cnt <= '0;
      clk32_pin_oe <= 1'b1;
      clk32_pin_out <= 1'b0;
      rst_pin_out <= 1'b0;
    end
    else if (!en_32khz)
    begin
      k32_cnt <= '0;
      clk32_pin_oe <= 1'b1;
    end
    else if (k32_cnt >= CNT_W'(WAVE_32K_HALF) - CNT_W'(1)) // R9
    begin
      k32_cnt <= '0;
      clk32_pin_oe <= ~clk32_pin_oe;
    end
    else
      k32_cnt <= k32_cnt + CNT_W'(1);
  end
endmodule
`default_nettype wire

// [hdl/rps_pkg.sv]
// constants shared by the reset-pin and shared-output supervision logic
`default_nettype none
package rps_pkg;
  // clock and timing
  localparam int CLK_KHZ = 125000;
  localparam int CLK_HZ = 125000000;
  localparam int CNT_W = 26;
  localparam int T_RST_MS = 250;
  localparam int T_REC_MS = 250;
  localparam int BUTTON_SETTLE_TIME_MS = 250;
  localparam int OSF_MS = 100;
  localparam int T_RST_CYC = T_RST_MS * CLK_KHZ;
  localparam int T_REC_CYC = T_REC_MS * CLK_KHZ;
  localparam int BUTTON_SETTLE_TIME_CYC = BUTTON_SETTLE_TIME_MS * CLK_KHZ;
  localparam int OSF_CYC = OSF_MS * CLK_KHZ;
  // square wave half periods in clock cycles, rounded down
  localparam int WAVE_1HZ_HALF = CLK_HZ / (2 * 1);
  localparam int WAVE_1K_HALF = CLK_HZ / (2 * 1024);
  localparam int WAVE_4K_HALF = CLK_HZ / (2 * 4096);
  localparam int WAVE_8K_HALF = CLK_HZ / (2 * 8192);
  localparam int WAVE_32K_HALF = CLK_HZ / (2 * 32768);
  // register map
  localparam logic [7:0] CTRL_ADDR = 8'h0e;
  localparam logic [7:0] CTRL_RESET = 8'h1c;
  localparam logic [7:0] RDATA_NONE = 8'h00;
  localparam int CTL_OSC_DIS = 7;
  localparam int CTL_RS_HI = 4;
  localparam int CTL_RS_LO = 3;
  localparam int CTL_IRQ_MODE = 2;
  localparam int CTL_A2_EN = 1;
  localparam int CTL_A1_EN = 0;
  localparam logic OSF_RESET = 1'b1;
  typedef enum logic [1:0] {
    ST_PFAIL = 2'b00,
    ST_RECOVER = 2'b01,
    ST_RUN = 2'b10,
    ST_PULSE = 2'b11
  } rps_state_t;
endpackage
`default_nettype wire

// [hdl/rps_lvl_if.sv]
// carrier of one asynchronous level and its filtered copy
`default_nettype none
interface rps_lvl_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// [hdl/rps_filt.sv]
// three-flop synchroniser that accepts a change once the last two flops agree
`default_nettype none
module rps_filt
  import rps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic init_val,
  rps_lvl_if.filt lvl
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge ref_clk)
  begin
    s1 <= lvl.raw;
    s2 <= s1;
    s3 <= s2;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      lvl.clean <= init_val;
    else if (s2 == s3)
      lvl.clean <= s3;
  end
endmodule
`default_nettype wire

// [bench/rps_board.sv]
// board model: pushbutton and pull-up on the open-drain reset wire
`default_nettype none
module rps_board (
  input wire logic pb_press,
  input wire logic rst_pin_oe,
  output logic rst_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up wins unless the device or the button pulls low
  assign rst_wire = rst_pin_oe & ~pb_press;
endmodule
`default_nettype wire

// [bench/rps_pin_supervision_properties.sv]
// port assertions for the supervision block
`default_nettype none
module rps_chk
  import rps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic vcc_ok,
  input wire logic osc_running,
  input wire logic osc_halt_clr,
  input wire logic alarm1_match,
  input wire logic alarm2_match,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] control_config,
  input wire logic osc_halt_flag,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic irq_or_wave_pin_out,
  input wire logic irq_or_wave_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hit;
  assign hit = alarm1_match & control_config[CTL_A1_EN] | alarm2_match & control_config[CTL_A2_EN];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_wr;
    reg_wr && reg_addr == CTRL_ADDR;
  endsequence
  sequence s_vup;
    !vcc_ok [*6] ##1 vcc_ok && !control_config[CTL_OSC_DIS];
  endsequence
  property p_wr;
    s_wr |=> control_config == $past(reg_wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("control write lost");
  property p_rd;
    reg_addr != CTRL_ADDR |=> reg_rdata == RDATA_NONE;
  endproperty
  a_rd: assert property (p_rd) else $error("unmapped read not zero");
  property p_irq;
    control_config[CTL_IRQ_MODE] |=> irq_or_wave_pin_oe == !$past(hit);
  endproperty
  a_irq: assert property (p_irq) else $error("alarm pin wrong");
  property p_clr;
    osc_running [*6] ##0 osc_halt_clr |=> !osc_halt_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("halt flag not cleared");
  property p_pf;
    !vcc_ok [*6] |-> !rst_pin_oe;
  endproperty
  a_pf: assert property (p_pf) else $error("reset released in power fail");
  property p_od;
    !rst_pin_out && !irq_or_wave_pin_out;
  endproperty
  a_od: assert property (p_od) else $error("open drain drives high");
  property p_rec;
    s_vup |-> (!rst_pin_oe || control_config[CTL_OSC_DIS]) [*8];
  endproperty
  a_rec: assert property (p_rec) else $error("recovery delay skipped");
  property p_rst;
    $rose(rstn) |-> control_config == CTRL_RESET && irq_or_wave_pin_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("bad power-up state");
endmodule
bind rps_pin_supervision rps_chk chk (
  .ref_clk(ref_clk), .rstn(rstn), .vcc_ok(vcc_ok), .osc_running(osc_running),
  .osc_halt_clr(osc_halt_clr), .alarm1_match(alarm1_match), .alarm2_match(alarm2_match),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .control_config(control_config), .osc_halt_flag(osc_halt_flag),
  .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
  .irq_or_wave_pin_out(irq_or_wave_pin_out), .irq_or_wave_pin_oe(irq_or_wave_pin_oe));
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the reset-pin and shared-pin supervision block
`default_nettype none
module tb_top
  import rps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] d; logic a1; logic a2; logic oe;} rps_row_t;
  rps_row_t rows [5] = '{'{8'h1c, 1'h1, 1'h1, 1'h1}, '{8'h1d, 1'h1, 1'h0, 1'h0},
    '{8'h1e, 1'h1, 1'h0, 1'h1}, '{8'h1e, 1'h0, 1'h1, 1'h0}, '{8'h1f, 1'h0, 1'h0, 1'h1}};
  logic ref_clk = 1'h0, rstn = 1'h0, vcc_ok = 1'h0, osc_running = 1'h1, a1 = 1'h0, a2 = 1'h0;
  logic halt_clr = 1'h0, reg_wr = 1'h0, pb = 1'h0, en32 = 1'h1;
  logic halt, rst_oe, sq_oe, k_oe, k_out, rst_wire;
  logic [7:0] reg_addr = 8'h0e, reg_wdata = 8'h00, rdata, cfg;
  int error_cnt = 0, checked = 0;
  rps_board board (.pb_press(pb), .rst_pin_oe(rst_oe), .rst_wire(rst_wire));
  rps_pin_supervision #(.T_RST(26'd20), .T_REC(26'd30), .T_BUTTON_SETTLE_TIME(26'd16), .T_OSF(26'd10))
  dut (
    .ref_clk(ref_clk), .rstn(rstn), .vcc_ok(vcc_ok), .osc_running(osc_running),
    .en_32khz(en32), .alarm1_match(a1), .alarm2_match(a2), .osc_halt_clr(halt_clr),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
    .control_config(cfg), .osc_halt_flag(halt), .rst_pin_in(rst_wire), .rst_pin_out(),
    .rst_pin_oe(rst_oe), .irq_or_wave_pin_out(), .irq_or_wave_pin_oe(sq_oe),
    .clk32_pin_out(k_out), .clk32_pin_oe(k_oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick(1);
    reg_wr = 1'h0;
  endtask
  task automatic done(input string s);
    $display("%s done", s);
  endtask
  task automatic complete_run;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // counts edges of the shared pin and the 32khz pin over n cycles
  task automatic toggles(input int n, output int w, output int k);
    logic pw, pk;
    w = 0;
    k = 0;
    repeat (n)
    begin
      pw = sq_oe;
      pk = k_oe;
      tick(1);
      w += int'(sq_oe != pw);
      k += int'(k_oe != pk);
    end
  endtask
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    #720000;
    error_cnt++;
    complete_run;
  end
  initial
  begin
    int w, k;
    tick(6);
    rstn = 1'h1;
    tick(1);
    chk(cfg, CTRL_RESET);
    chk_bit(halt, OSF_RESET);
    chk_bit(sq_oe, 1'h1);
    chk_bit(rst_oe, 1'h0);
    done("reset");
    foreach (rows[i])
    begin
      wr(8'h0e, rows[i].d);
      a1 = rows[i].a1;
      a2 = rows[i].a2;
      tick(2);
      chk(rdata, rows[i].d);
      chk_bit(sq_oe, rows[i].oe);
    end
    // the address of this write stays up for the read-back
    wr(8'h0f, 8'h00);
    tick(2);
    chk(rdata, RDATA_NONE);
    chk(cfg, 8'h1f);
    reg_addr = 8'h0e;
    done("registers");
    vcc_ok = 1'h1;
    tick(25);
    chk_bit(rst_oe, 1'h0);
    tick(15);
    chk_bit(rst_oe, 1'h1);
    pb = 1'h1;
    tick(8);
    pb = 1'h0;
    tick(30);
    chk_bit(rst_oe, 1'h1);
    pb = 1'h1;
    tick(24);
    chk_bit(rst_oe, 1'h0);
    pb = 1'h0;
    tick(11);
    chk_bit(rst_oe, 1'h0);
    tick(15);
    chk_bit(rst_oe, 1'h1);
    done("reset pin");
    halt_clr = 1'h1;
    tick(1);
    halt_clr = 1'h0;
    chk_bit(halt, 1'h0);
    osc_running = 1'h0;
    tick(8);
    chk_bit(halt, 1'h0);
    tick(10);
    chk_bit(halt, 1'h1);
    osc_running = 1'h1;
    vcc_ok = 1'h0;
    tick(6);
    chk_bit(rst_oe, 1'h0);
    wr(8'h0e, 8'h9c);
    tick(1);
    chk(rdata, 8'h9c);
    vcc_ok = 1'h1;
    tick(6);
    chk_bit(rst_oe, 1'h1);
    done("halt and bypass");
    wr(8'h0e, 8'h18);
    tick(8000);
    toggles(2 * WAVE_8K_HALF, w, k);
    chk(8'(w), 8'h02);
    chk(8'(k / 2), 8'(WAVE_8K_HALF / WAVE_32K_HALF));
    chk_bit(k_out, 1'h0);
    wr(8'h0e, 8'h10);
    tick(16000);
    toggles(2 * WAVE_4K_HALF, w, k);
    chk(8'(w), 8'h02);
    en32 = 1'h0;
    tick(2);
    toggles(2 * WAVE_32K_HALF, w, k);
    chk_bit(k_oe, 1'h1);
    chk(8'(k), 8'h00);
    done("wave");
    // supply returns with the oscillator stopped: hold time instead of recovery
    vcc_ok = 1'h0;
    osc_running = 1'h0;
    tick(8);
    chk_bit(rst_oe, 1'h0);
    vcc_ok = 1'h1;
    tick(22);
    chk_bit(rst_oe, 1'h0);
    tick(3);
    chk_bit(rst_oe, 1'h1);
    done("stopped oscillator");
    complete_run;
  end
endmodule
`default_nettype wire
